// File: logic/conduction_defs.svh
// register offsets, field positions, reset values and match counts
// Operation
// - output register has load-timing part and double-buffered port-output part
// - six lines; upper polarity from bit 12, lower polarity from bit 11
// - polarity bit 0 means low-active lines, 1 means high-active lines
// - wave select bits W=10, V=9, U=8; 0 fixed level, 1 pwm
// - level fields U 1:0, V 3:2, W 5:4; load timing in 7:6
// - load timing 00 async, 01 counter=1, 10 counter=period, 11 either
// - wave and level writes land in buffer, copied active at chosen moment
// - fixed-level phase holds static levels from its level field
// - high-active: fixed LL,LH,HL,HH; pwm PWM/PWM, L/PWM, PWM/L, PWM/PWM
// - low-active: fixed HH,HL,LH,LL; pwm PWM/PWM, H/PWM, PWM/H, PWM/PWM
// - V and W phases map like U with their own fields
// - run bit clear stops and clears counter, all lines high impedance
`ifndef CONDUCTION_DEFS_SVH
`define CONDUCTION_DEFS_SVH
`define OUT_CTRL_OFS 32'hffffc318
`define RUN_CTRL_OFS 32'hffffc340
`define ACT_STAT_OFS 32'hffffc344
`define UPOL_BIT 12
`define LPOL_BIT 11
`define SEL_LSB 8
`define TIMING_LSB 6
`define CODE_LSB 0
`define RUN_BIT 0
`define OUT_CTRL_RST 16'h0000
`define CNT_MATCH_ONE 1
`endif

// File: logic/conduction_pkg.sv
// types shared by the conduction control files
`default_nettype none
package conduction_pkg;
    typedef enum logic [1:0] {
        load_async,
        load_at_one,
        load_at_period,
        load_at_both
    } load_mode_e;
endpackage
`default_nettype wire

// File: logic/load_timing_select.sv
// picks the counter match that transfers the buffered phase settings
`include "conduction_defs.svh"
`default_nettype none
module load_timing_select #(
    parameter int CNT_W = 16
) (
    // timing choice
    input wire conduction_pkg::load_mode_e mode,
    // counter side
    input wire logic [CNT_W-1:0] pwm_counter_value,
    input wire logic [CNT_W-1:0] period_value,
    // transfer strobe
    output logic sync_load
);
    logic at_one;
    logic at_period;

    assign at_one = (pwm_counter_value == CNT_W'(`CNT_MATCH_ONE));
    assign at_period = (pwm_counter_value == period_value);

    always_comb begin
        case (mode)
            conduction_pkg::load_at_one: sync_load = at_one;
            conduction_pkg::load_at_period: sync_load = at_period;
            conduction_pkg::load_at_both: sync_load = at_one | at_period;
            default: sync_load = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// File: logic/phase_output_map.sv
// one phase: level field and wave select to upper and lower line levels
`default_nettype none
module phase_output_map (
    // phase settings
    input wire logic wave_select,
    input wire logic [1:0] level_select,
    input wire logic upper_pol,
    input wire logic lower_pol,
    // pwm waveform of this phase
    input wire logic wave,
    // line levels
    output logic up_level,
    output logic lo_level
);
    logic up_active;
    logic lo_active;

    always_comb begin
        if (wave_select) begin
            up_active = (level_select == 2'h1) ? 1'b0 : wave;
            lo_active = (level_select == 2'h2) ? 1'b0 : ~wave;
        end else begin
            up_active = level_select[1];
            lo_active = level_select[0];
        end
    end

    // high-active passes the level, low-active inverts it
    assign up_level = upper_pol ? up_active : ~up_active;
    assign lo_level = lower_pol ? lo_active : ~lo_active;
endmodule
`default_nettype wire

// File: logic/three_phase_conduction_control.sv
// conduction control: register port, buffered phase settings, six gate lines
//
// The plain strobed port was decided locally.
`include "conduction_defs.svh"
`default_nettype none
module three_phase_conduction_control #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 16,
    parameter int CNT_W = 16
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // pwm counter side
    input wire logic [CNT_W-1:0] pwm_counter_value,
    input wire logic [CNT_W-1:0] period_value,
    input wire logic [2:0] phase_wave,
    output logic counter_clear,
    // gate lines: [2:0] upper u,v,w; [5:3] lower u,v,w
    output logic [5:0] gate_out,
    output logic [5:0] gate_oe_n
);
    // ****************************************
    // parameter checks
    // ****************************************
    if (DATA_W != 16) begin : g_bad_data
        $error("data width must be 16");
    end
    if (ADDR_W != 32) begin : g_bad_addr
        $error("address width must be 32");
    end
    if (CNT_W < 2) begin : g_bad_cnt
        $error("counter width must be at least 2");
    end

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr_out;
    logic wr_run;
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        wr_out = 1'b0;
        wr_run = 1'b0;
        if (hit(reg_addr, `OUT_CTRL_OFS)) begin
            wr_out = reg_wr;
        end else if (hit(reg_addr, `RUN_CTRL_OFS)) begin
            wr_run = reg_wr;
        end
    end

    // ****************************************
    // settings
    // ****************************************
    logic waveform_run;
    conduction_pkg::load_mode_e output_load_timing;
    logic upper_line_polarity;
    logic lower_line_polarity;
    logic [2:0] buf_wave_select;
    logic [5:0] buf_level_select;
    logic [2:0] act_wave_select;
    logic [5:0] act_level_select;
    logic sync_load;
    logic async_write;

    // run bit; software is expected to stop before touching polarity or timing
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            waveform_run <= 1'b0;
        end else if (clk_en && wr_run) begin
            waveform_run <= reg_wdata[`RUN_BIT];
        end
    end

    // load-timing part and polarity: single-buffered
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            output_load_timing <= conduction_pkg::load_async;
            upper_line_polarity <= 1'b0;
            lower_line_polarity <= 1'b0;
        end else if (clk_en && wr_out) begin
            output_load_timing <=
                conduction_pkg::load_mode_e'(reg_wdata[`TIMING_LSB +: 2]);
            upper_line_polarity <= reg_wdata[`UPOL_BIT];
            lower_line_polarity <= reg_wdata[`LPOL_BIT];
        end
    end

    // port-output part: write side of the double buffer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            buf_wave_select <= 3'h0;
            buf_level_select <= 6'h00;
        end else if (clk_en && wr_out) begin
            buf_wave_select <= reg_wdata[`SEL_LSB +: 3];
            buf_level_select <= reg_wdata[`CODE_LSB +: 6];
        end
    end

    load_timing_select #(
        .CNT_W(CNT_W)
    ) u_timing (
        .mode(output_load_timing),
        .pwm_counter_value(pwm_counter_value),
        .period_value(period_value),
        .sync_load(sync_load)
    );

    assign async_write = wr_out && (output_load_timing == conduction_pkg::load_async);

    // active side: async takes the write itself, sync copies the buffer at a match
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            act_wave_select <= 3'h0;
            act_level_select <= 6'h00;
        end else if (clk_en) begin
            if (async_write) begin
                act_wave_select <= reg_wdata[`SEL_LSB +: 3];
                act_level_select <= reg_wdata[`CODE_LSB +: 6];
            end else if (sync_load) begin
                act_wave_select <= buf_wave_select;
                act_level_select <= buf_level_select;
            end
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_comb begin
        next_rdata = 16'h0000;
        if (hit(reg_addr, `OUT_CTRL_OFS)) begin
            next_rdata[`UPOL_BIT] = upper_line_polarity;
            next_rdata[`LPOL_BIT] = lower_line_polarity;
            next_rdata[`SEL_LSB +: 3] = buf_wave_select;
            next_rdata[`TIMING_LSB +: 2] = output_load_timing;
            next_rdata[`CODE_LSB +: 6] = buf_level_select;
        end else if (hit(reg_addr, `RUN_CTRL_OFS)) begin
            next_rdata[`RUN_BIT] = waveform_run;
        end else if (hit(reg_addr, `ACT_STAT_OFS)) begin
            next_rdata[`SEL_LSB +: 3] = act_wave_select;
            next_rdata[`CODE_LSB +: 6] = act_level_select;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? next_rdata : 16'h0000;
        end
    end

    // ****************************************
    // phase mapping
    // ****************************************
    logic [2:0] up_level;
    logic [2:0] lo_level;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        phase_output_map u_map (
            .wave_select(act_wave_select[p]),
            .level_select(act_level_select[2*p +: 2]),
            .upper_pol(upper_line_polarity),
            .lower_pol(lower_line_polarity),
            .wave(phase_wave[p]),
            .up_level(up_level[p]),
            .lo_level(lo_level[p])
        );
    end

    // ****************************************
    // gate lines and counter control
    // ****************************************
    // stopped: lines released to high impedance, counter held cleared
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gate_out <= 6'h00;
            gate_oe_n <= 6'h3f;
            counter_clear <= 1'b1;
        end else if (clk_en) begin
            counter_clear <= ~waveform_run;
            if (waveform_run) begin
                gate_out <= {lo_level, up_level};
                gate_oe_n <= 6'h00;
            end else begin
                gate_out <= 6'h00;
                gate_oe_n <= 6'h3f;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_async_load;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && async_write) |=> act_level_select == $past(reg_wdata[5:0]);
    endproperty
    a_async_load: assert property (p_async_load)
        else $error("async write did not reach active settings");

    property p_hold_between_loads;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && !sync_load && !async_write) |=> $stable(act_wave_select)
            && $stable(act_level_select);
    endproperty
    a_hold_between_loads: assert property (p_hold_between_loads)
        else $error("active settings changed without a load");

    property p_load_at_one;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && !wr_out && output_load_timing == conduction_pkg::load_at_one
            && pwm_counter_value == CNT_W'(1))
        |=> act_level_select == $past(buf_level_select)
            && act_wave_select == $past(buf_wave_select);
    endproperty
    a_load_at_one: assert property (p_load_at_one)
        else $error("buffer not transferred at counter one");

    property p_period_only;
        @(posedge sys_clk) disable iff (!rstn)
        (output_load_timing == conduction_pkg::load_at_period
            && pwm_counter_value != period_value) |-> !sync_load;
    endproperty
    a_period_only: assert property (p_period_only)
        else $error("transfer away from period match");

    property p_stopped_hiz;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && !waveform_run) |=> gate_oe_n == 6'h3f && counter_clear;
    endproperty
    a_stopped_hiz: assert property (p_stopped_hiz)
        else $error("lines driven while stopped");

    property p_run_drives;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && waveform_run) |=> gate_oe_n == 6'h00 && !counter_clear;
    endproperty
    a_run_drives: assert property (p_run_drives)
        else $error("lines not driven while running");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && reg_rd && hit(reg_addr, `OUT_CTRL_OFS)) |=> reg_rdata[15:13] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_fixed_upper_u;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && waveform_run && !act_wave_select[0])
        |=> gate_out[0] == $past(act_level_select[1] ~^ upper_line_polarity);
    endproperty
    a_fixed_upper_u: assert property (p_fixed_upper_u)
        else $error("fixed upper u level wrong");

    property p_fixed_lower_w;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && waveform_run && !act_wave_select[2])
        |=> gate_out[5] == $past(act_level_select[4] ~^ lower_line_polarity);
    endproperty
    a_fixed_lower_w: assert property (p_fixed_lower_w)
        else $error("fixed lower w level wrong");

    property p_pwm_upper_off;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && waveform_run && act_wave_select[1] && act_level_select[3:2] == 2'h1)
        |=> gate_out[1] == $past(~upper_line_polarity);
    endproperty
    a_pwm_upper_off: assert property (p_pwm_upper_off)
        else $error("upper v not inactive for code 01");

    property p_pwm_complement;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && waveform_run && act_wave_select[0] && act_level_select[1:0] == 2'h0
            && upper_line_polarity && lower_line_polarity)
        |=> gate_out[3] == ~gate_out[0];
    endproperty
    a_pwm_complement: assert property (p_pwm_complement)
        else $error("lower u not complementary to upper u");

    property p_polarity_stored;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && wr_out) |=> upper_line_polarity == $past(reg_wdata[12])
            && lower_line_polarity == $past(reg_wdata[11]);
    endproperty
    a_polarity_stored: assert property (p_polarity_stored)
        else $error("polarity bits not stored");

    property p_run_readback;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && reg_rd && hit(reg_addr, `RUN_CTRL_OFS) && !wr_run)
        |=> reg_rdata == {15'h0000, $past(waveform_run)} ##1 !$past(clk_en)
            || reg_rdata == 16'h0000 || $past(reg_rd);
    endproperty
    a_run_readback: assert property (p_run_readback)
        else $error("run bit readback wrong");

    property p_lines_low_stopped;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && !waveform_run) |=> gate_out == 6'h00;
    endproperty
    a_lines_low_stopped: assert property (p_lines_low_stopped)
        else $error("line levels not cleared while stopped");

    property p_buffer_written;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && wr_out) |=> buf_wave_select == $past(reg_wdata[10:8])
            && buf_level_select == $past(reg_wdata[5:0]);
    endproperty
    a_buffer_written: assert property (p_buffer_written)
        else $error("write did not land in the buffer");

    property p_timing_stored;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && wr_out) |=> output_load_timing == $past(reg_wdata[7:6]);
    endproperty
    a_timing_stored: assert property (p_timing_stored)
        else $error("load timing field not stored");

    property p_pwm_lower_off;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && waveform_run && act_wave_select[2] && act_level_select[5:4] == 2'h2)
        |=> gate_out[5] == $past(~lower_line_polarity);
    endproperty
    a_pwm_lower_off: assert property (p_pwm_lower_off)
        else $error("lower w not inactive for code 10");

    property p_pwm_upper_follows;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && waveform_run && act_wave_select[2] && act_level_select[5:4] != 2'h1)
        |=> gate_out[2] == $past(phase_wave[2] ~^ upper_line_polarity);
    endproperty
    a_pwm_upper_follows: assert property (p_pwm_upper_follows)
        else $error("upper w does not follow the waveform");

    property p_pwm_lower_follows;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && waveform_run && act_wave_select[0] && act_level_select[1:0] != 2'h2)
        |=> gate_out[3] == $past(~phase_wave[0] ~^ lower_line_polarity);
    endproperty
    a_pwm_lower_follows: assert property (p_pwm_lower_follows)
        else $error("lower u does not follow the inverted waveform");
endmodule
`default_nettype wire

// File: bench/gate_driver_model.sv
// gate driver model standing behind the six gate lines
`default_nettype none
module gate_driver_model (
    // gate lines from the block
    input wire logic [5:0] gate_out,
    input wire logic [5:0] gate_oe_n,
    // what the driver inputs see
    output logic [5:0] drive_level,
    output logic [5:0] line_float
);
    timeunit 1ns;
    timeprecision 1ps;
    // driver inputs carry pull-downs, so a released line reads low
    assign line_float = gate_oe_n;
    assign drive_level = gate_out & ~gate_oe_n;
endmodule
`default_nettype wire

// File: bench/tb_three_phase_conduction_control.sv
// self-checking bench for the three-phase conduction control block
`include "conduction_defs.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_three_phase_conduction_control;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] w; logic [2:0] wave; logic [5:0] g;} row_s;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] cnt = 16'h0005;
    logic [15:0] prd = 16'h0009;
    logic [2:0] wave = '0;
    logic counter_clear;
    logic [5:0] gate_out;
    logic [5:0] gate_oe_n;
    logic [5:0] drv;
    logic [5:0] flt;
    row_s rows [64];
    int err_count = 0;
    int n_tests = 0;

    always #12.5 sys_clk = ~sys_clk;

    three_phase_conduction_control DUT (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_counter_value(cnt), .period_value(prd),
        .phase_wave(wave), .counter_clear(counter_clear), .gate_out(gate_out),
        .gate_oe_n(gate_oe_n));
    gate_driver_model drivers (.gate_out(gate_out), .gate_oe_n(gate_oe_n),
        .drive_level(drv), .line_float(flt));

    // ****************
    // helpers
    // ****************
    function automatic logic [5:0] exp_gate(logic [15:0] w, logic [2:0] wv);
        logic [5:0] g;
        logic ua;
        logic la;
        g = '0;
        for (int p = 0; p < 3; p++) begin
            if (w[`SEL_LSB+p]) begin
                ua = (w[2*p+:2] == 2'b01) ? 1'b0 : wv[p];
                la = (w[2*p+:2] == 2'b10) ? 1'b0 : ~wv[p];
            end else begin
                ua = w[2*p+1];
                la = w[2*p];
            end
            g[p] = w[`UPOL_BIT] ? ua : ~ua;
            g[p+3] = w[`LPOL_BIT] ? la : ~la;
        end
        return g;
    endfunction

    task automatic wr(logic [31:0] a, logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // returns one step after the edge that registers the read data
    task automatic rd(logic [31:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        summarize();
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        logic [15:0] d;
        logic [1:0] c;
        repeat (4) @(posedge sys_clk);
        `CHK("rdata in reset", 16'h0000, reg_rdata)
        `CHK("oe in reset", 6'h3f, gate_oe_n)
        `CHK("clear in reset", 1'b1, counter_clear)
        rstn <= 1'b1;
        rd(`OUT_CTRL_OFS, d);
        `CHK("ctrl reset", `OUT_CTRL_RST, d)
        for (int i = 0; i < 64; i++) begin
            c = i[2:1];
            rows[i].w = {3'b000, i[5:4], {3{i[3]}}, 2'b00, c + 2'd2, c + 2'd1, c};
            rows[i].wave = i[0] ? 3'b101 : 3'b010;
            rows[i].g = exp_gate(rows[i].w, rows[i].wave);
        end
        foreach (rows[i]) begin
            wr(`RUN_CTRL_OFS, 16'h0000);
            wr(`OUT_CTRL_OFS, rows[i].w);
            wave <= rows[i].wave;
            rd(`OUT_CTRL_OFS, d);
            `CHK("ctrl", rows[i].w, d)
            `CHK("oe stopped", 6'h3f, gate_oe_n)
            `CHK("floating", 6'h3f, flt)
            `CHK("clear stopped", 1'b1, counter_clear)
            `CHK("lines stopped", 6'h00, gate_out)
            `CHK("pulled low", 6'h00, drv)
            wr(`RUN_CTRL_OFS, 16'h0001);
            rd(`RUN_CTRL_OFS, d);
            `CHK("run readback", 16'h0001, d)
            `CHK("clear run", 1'b0, counter_clear)
            `CHK("oe run", 6'h00, gate_oe_n)
            `CHK("lines", rows[i].g, gate_out)
            `CHK("driver", rows[i].g, drv)
        end
        wr(`RUN_CTRL_OFS, 16'h0000);
        for (int t = 1; t < 4; t++) begin
            wr(`OUT_CTRL_OFS, 16'h0000);
            wr(`OUT_CTRL_OFS, 16'h0000);
            wr(`OUT_CTRL_OFS, 16'(t << 6));
            wr(`OUT_CTRL_OFS, 16'(t << 6) | 16'h072d);
            rd(`ACT_STAT_OFS, d);
            `CHK("held", 16'h0000, d)
            rd(`OUT_CTRL_OFS, d);
            `CHK("buffer", 16'(t << 6) | 16'h072d, d)
            @(posedge sys_clk);
            cnt <= 16'h0001;
            @(posedge sys_clk);
            cnt <= 16'h0005;
            rd(`ACT_STAT_OFS, d);
            `CHK("at one", t[0] ? 16'h072d : 16'h0000, d)
            @(posedge sys_clk);
            cnt <= prd;
            @(posedge sys_clk);
            cnt <= 16'h0005;
            rd(`ACT_STAT_OFS, d);
            `CHK("at period", 16'h072d, d)
        end
        wr(`OUT_CTRL_OFS, 16'h0000);
        wr(`OUT_CTRL_OFS, 16'h0000);
        wr(`OUT_CTRL_OFS, 16'hff3f);
        rd(`OUT_CTRL_OFS, d);
        `CHK("reserved", 16'h1f3f, d)
        wr(`ACT_STAT_OFS, 16'h0000);
        rd(`ACT_STAT_OFS, d);
        `CHK("async active", 16'h073f, d)
        wr(32'hffffc31c, 16'hffff);
        rd(32'hffffc31c, d);
        `CHK("unmapped", 16'h0000, d)
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(`OUT_CTRL_OFS, 16'h0000);
        clk_en <= 1'b1;
        rd(`OUT_CTRL_OFS, d);
        `CHK("frozen", 16'h1f3f, d)
        wr(`RUN_CTRL_OFS, 16'h0001);
        @(posedge sys_clk);
        rstn <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK("oe mid reset", 6'h3f, gate_oe_n)
        @(posedge sys_clk);
        rstn <= 1'b1;
        rd(`OUT_CTRL_OFS, d);
        `CHK("ctrl after reset", 16'h0000, d)
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
